// file: design/pem_pkg.sv
// Shared constants and types for the extended PHY management register bank.
// Assumes one 40 MHz system clock and an AHB-Lite master with word accesses.
package pem_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam int IDX_W = 6;
	localparam int ADDR_LSB = 2;
	localparam logic [5:0] IDX_NEXT_PAGE = 6'h07;
	localparam logic [5:0] IDX_PCS_CTRL = 6'h10;
	localparam logic [5:0] IDX_AN_STATE_A = 6'h11;
	localparam logic [5:0] IDX_AN_STATE_B = 6'h12;
	localparam logic [5:0] IDX_USER_OUT = 6'h14;
	localparam logic [5:0] IDX_ERR_COUNT = 6'h15;

	// Bus encodings.
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'h0;

	// Next-page transmit word fields.
	localparam int NP_MORE = 15;
	localparam int NP_ACK = 14;
	localparam int NP_MESSAGE = 13;
	localparam int NP_COMPLY = 12;
	localparam int NP_TOGGLE = 11;
	localparam int NP_CODE_HI = 10;

	// PCS control fields.
	localparam int PCS_LOCK = 15;
	localparam int PCS_TEST_HI = 11;
	localparam int PCS_TEST_LO = 4;
	localparam int PCS_SCOPE = 3;
	localparam int PCS_SCAN = 2;
	localparam int PCS_WRAP = 1;
	localparam int PCS_SPEEDUP = 0;

	// Error counter fields.
	localparam int ERR_MODE = 0;
	localparam int ERR_RX_HI = 7;
	localparam int ERR_FC_LO = 8;
	localparam int ERR_FC_HI = 11;
	localparam int ERR_DC_LO = 12;
	localparam int ERR_DC_HI = 15;
	localparam logic [15:0] ERR_MAX16 = 16'hFFFF;
	localparam logic [15:0] ERR_MAX8 = 16'h00FF;
	localparam logic [15:0] ERR_MAX4 = 16'h000F;

	// Reset values.
	localparam logic [15:0] RST_WORD16 = 16'h0000;
	localparam logic [31:0] RST_WORD32 = 32'h0000_0000;

	// Link monitor interval, slow and sped up.
	localparam int CLK_MHZ = 40;
	localparam int LMON_SLOW_NS = 620_000;
	localparam int LMON_FAST_NS = 10_000;
	localparam int LMON_W = 15;
	localparam int LMON_SLOW_CYCLES = LMON_SLOW_NS * CLK_MHZ / 1000;
	localparam int LMON_FAST_CYCLES = LMON_FAST_NS * CLK_MHZ / 1000;

	typedef enum logic {
		PEM_BUS_IDLE,
		PEM_BUS_ACCESS
	} pem_bus_state_t;

	// Arbitration and link pulse state flags from the autonegotiation logic.
	typedef struct packed {
		logic [12:0] stateA;
		logic flpCapture;
		logic flpClock;
		logic flpData0;
		logic flpData1;
		logic [14:0] stateB;
	} pem_an_flags_t;

	// Next-page exchange signals from the autonegotiation logic.
	typedef struct packed {
		logic linkAck;
		logic baseToggle;
		logic pageStart;
		logic pageExchanged;
	} pem_np_link_t;

	// One-cycle event pulses counted by the error counter.
	typedef struct packed {
		logic receiveErrorEvent;
		logic falseCarrierEvent;
		logic disconnectEvent;
	} pem_events_t;

	// Controls driven into the PCS.
	typedef struct packed {
		logic fullLoopback;
		logic collisionOff;
		logic txIdleForce;
		logic wrapLoopback;
		logic fastTimer;
		logic [14:0] linkMonitorLimit;
	} pem_pcs_out_t;

	typedef struct packed {
		pem_bus_state_t busState;
		logic accWrite;
		logic accRead;
		logic [5:0] accIndex;
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
		logic npMore;
		logic npMessage;
		logic npComply;
		logic npToggle;
		logic [10:0] npCode;
		logic [7:0] generic_test_field;
		logic scope;
		logic scan;
		logic forceWrap;
		logic speedup;
		logic [15:0] userWord;
		logic errMode;
		logic [15:0] errCount;
		pem_pcs_out_t pcsOut;
	} pem_state_t;

endpackage : pem_pkg

// file: design/pem_regs.sv
// Extended PHY management registers: next-page word, PCS control, autonegotiation state,
// user output word and the receive error counter, all behind an AHB-Lite slave.
// Assumes inputs synchronous to clk_sys and event inputs that are one-cycle pulses.
//
// Operation
// - Next-page bit: 0 marks the last page, 1 means another page follows.
// - Acknowledge bit of the link code word readable in the next-page word.
// - Message-page bit: 0 unformatted page, 1 formatted message page.
// - Comply bit: 1 will comply with the message, 0 cannot comply.
// - Toggle bit reads as inverse of the previously exchanged toggle.
// - First next page starts toggle at inverse of base word bit 11.
// - Low eleven bits hold a writable message or unformatted code.
// - PCS control top bit shows descrambler lock, read only.
// - Three bits below the lock indication always read zero.
// - Eight test bits are writable and have no effect on the PCS.
// - Scope bit high: full PCS loopback; low: loopback only disables collision.
// - Forced wrap loops back without idle forcing or collision disable.
// - Speedup bit shortens link monitor from 620 us to 10 us, like fast input.
// - State register A shows arbitration flags; top three bits read zero.
// - State register B shows FLP/NLP flags; top bit when FLP receive active.
// - In 16-bit mode the whole word counts receive errors, cleared on read.
// - In 8-bit mode low byte counts errors, bits 11:8 false carriers.
// - In 8-bit mode top four bits count disconnects, cleared on read.
//
// Register access over AHB-Lite is this design's own decision.
module pem_regs #(
	parameter logic [14:0] LinkMonitorCycles = 15'(pem_pkg::LMON_SLOW_CYCLES)
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire pem_pkg::pem_np_link_t npLink,
	input wire logic descramblerLock,
	input wire logic loopbackEnable,
	input wire logic fast_timer_input,
	input wire pem_pkg::pem_an_flags_t anFlags,
	input wire pem_pkg::pem_events_t events,
	output pem_pkg::pem_pcs_out_t pcsOut,
	output logic [15:0] user_word_output_bus
);
	import pem_pkg::*;

	// Saturating increment limited to a field maximum, so a full field holds its value.
	function automatic logic [15:0] satInc(input logic [15:0] value, input logic [15:0] maxValue);
		logic [15:0] result;
		result = value;
		if (value != maxValue) begin
			result = value + 16'h0001;
		end
		return result;
	endfunction : satInc

	pem_state_t state_reg;
	pem_state_t state_next;

	logic addrValid;
	logic [5:0] addrIndex;
	logic [15:0] readWord;
	logic [15:0] errFresh;
	logic [15:0] errBumped;
	logic [15:0] rxField;
	logic [15:0] fcField;
	logic [15:0] dcField;
	logic errRead;

	assign addrValid = hsel && htrans[1] && hready;
	assign addrIndex = haddr[ADDR_LSB + IDX_W - 1:ADDR_LSB];

	always_comb begin
		readWord = RST_WORD16;
		case (state_reg.accIndex)
			IDX_NEXT_PAGE: begin
				readWord[NP_MORE] = state_reg.npMore;
				readWord[NP_ACK] = npLink.linkAck;
				readWord[NP_MESSAGE] = state_reg.npMessage;
				readWord[NP_COMPLY] = state_reg.npComply;
				readWord[NP_TOGGLE] = state_reg.npToggle;
				readWord[NP_CODE_HI:0] = state_reg.npCode;
			end
			IDX_PCS_CTRL: begin
				readWord[PCS_LOCK] = descramblerLock;
				readWord[PCS_TEST_HI:PCS_TEST_LO] = state_reg.generic_test_field;
				readWord[PCS_SCOPE] = state_reg.scope;
				readWord[PCS_SCAN] = state_reg.scan;
				readWord[PCS_WRAP] = state_reg.forceWrap;
				readWord[PCS_SPEEDUP] = state_reg.speedup;
			end
			IDX_AN_STATE_A: begin
				readWord = {3'h0, anFlags.stateA};
			end
			IDX_AN_STATE_B: begin
				readWord = {anFlags.flpCapture | anFlags.flpClock | anFlags.flpData0 | anFlags.flpData1,
					anFlags.stateB};
			end
			IDX_USER_OUT: begin
				readWord = state_reg.userWord;
			end
			IDX_ERR_COUNT: begin
				readWord = state_reg.errCount;
			end
			default: begin
				readWord = RST_WORD16;
			end
		endcase
	end

	// The counter fields are advanced from the held count, or from zero when a read clears them.
	always_comb begin
		// A refused non-word write is not a read, so it must leave the counter alone.
		errRead = (state_reg.busState == PEM_BUS_ACCESS) && state_reg.accRead
			&& (state_reg.accIndex == IDX_ERR_COUNT);
		errFresh = errRead ? RST_WORD16 : state_reg.errCount;
		rxField = satInc(16'(errFresh[ERR_RX_HI:0]), ERR_MAX8);
		fcField = satInc(16'(errFresh[ERR_FC_HI:ERR_FC_LO]), ERR_MAX4);
		dcField = satInc(16'(errFresh[ERR_DC_HI:ERR_DC_LO]), ERR_MAX4);
		errBumped = errFresh;
		if (!state_reg.errMode) begin
			if (events.receiveErrorEvent) begin
				errBumped = satInc(errFresh, ERR_MAX16);
			end
		end else begin
			if (events.receiveErrorEvent) begin
				errBumped[ERR_RX_HI:0] = rxField[ERR_RX_HI:0];
			end
			if (events.falseCarrierEvent) begin
				errBumped[ERR_FC_HI:ERR_FC_LO] = fcField[ERR_FC_HI - ERR_FC_LO:0];
			end
			if (events.disconnectEvent) begin
				errBumped[ERR_DC_HI:ERR_DC_LO] = dcField[ERR_DC_HI - ERR_DC_LO:0];
			end
		end
	end

	always_comb begin
		state_next = state_reg;
		state_next.hresp = HRESP_OKAY;
		state_next.errCount = errBumped;

		// A new first page reloads the toggle; otherwise each exchange flips it.
		if (npLink.pageStart) begin
			state_next.npToggle = !npLink.baseToggle;
		end else if (npLink.pageExchanged) begin
			state_next.npToggle = !state_reg.npToggle;
		end

		case (state_reg.busState)
			PEM_BUS_IDLE: begin
				state_next.hreadyout = 1'b1;
				if (addrValid) begin
					state_next.busState = PEM_BUS_ACCESS;
					state_next.accWrite = hwrite && (hsize == HSIZE_WORD);
					state_next.accRead = !hwrite;
					state_next.accIndex = addrIndex;
					state_next.hreadyout = 1'b0;
				end
			end
			PEM_BUS_ACCESS: begin
				// One wait state lets the read data come from a flip-flop.
				state_next.busState = PEM_BUS_IDLE;
				state_next.hreadyout = 1'b1;
				state_next.hrdata = state_reg.accRead ? {16'h0000, readWord} : RST_WORD32;
				if (state_reg.accWrite) begin
					state_next.hrdata = RST_WORD32;
					case (state_reg.accIndex)
						IDX_NEXT_PAGE: begin
							state_next.npMore = hwdata[NP_MORE];
							state_next.npMessage = hwdata[NP_MESSAGE];
							state_next.npComply = hwdata[NP_COMPLY];
							state_next.npCode = hwdata[NP_CODE_HI:0];
						end
						IDX_PCS_CTRL: begin
							state_next.generic_test_field = hwdata[PCS_TEST_HI:PCS_TEST_LO];
							state_next.scope = hwdata[PCS_SCOPE];
							state_next.scan = hwdata[PCS_SCAN];
							state_next.forceWrap = hwdata[PCS_WRAP];
							state_next.speedup = hwdata[PCS_SPEEDUP];
						end
						IDX_USER_OUT: begin
							state_next.userWord = hwdata[15:0];
						end
						IDX_ERR_COUNT: begin
							state_next.errMode = hwdata[ERR_MODE];
						end
						default: begin
							state_next.hrdata = RST_WORD32;
						end
					endcase
				end
			end
			default: begin
				state_next.busState = PEM_BUS_IDLE;
				state_next.hreadyout = 1'b1;
			end
		endcase

		// The generic test bits and scan bit are held for readback only.
		state_next.pcsOut.fullLoopback = loopbackEnable && state_next.scope;
		state_next.pcsOut.collisionOff = loopbackEnable;
		state_next.pcsOut.txIdleForce = loopbackEnable && state_next.scope;
		state_next.pcsOut.wrapLoopback = state_next.forceWrap;
		state_next.pcsOut.fastTimer = state_next.speedup || fast_timer_input;
		state_next.pcsOut.linkMonitorLimit = state_next.pcsOut.fastTimer
			? 15'(LMON_FAST_CYCLES) : LinkMonitorCycles;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg.busState <= PEM_BUS_IDLE;
			state_reg.accWrite <= 1'b0;
			state_reg.accRead <= 1'b0;
			state_reg.accIndex <= 6'h00;
			state_reg.hreadyout <= 1'b1;
			state_reg.hresp <= HRESP_OKAY;
			state_reg.hrdata <= RST_WORD32;
			state_reg.npMore <= 1'b0;
			state_reg.npMessage <= 1'b0;
			state_reg.npComply <= 1'b0;
			state_reg.npToggle <= 1'b0;
			state_reg.npCode <= 11'h000;
			state_reg.generic_test_field <= 8'h00;
			state_reg.scope <= 1'b0;
			state_reg.scan <= 1'b0;
			state_reg.forceWrap <= 1'b0;
			state_reg.speedup <= 1'b0;
			state_reg.userWord <= RST_WORD16;
			state_reg.errMode <= 1'b0;
			state_reg.errCount <= RST_WORD16;
			state_reg.pcsOut.fullLoopback <= 1'b0;
			state_reg.pcsOut.collisionOff <= 1'b0;
			state_reg.pcsOut.txIdleForce <= 1'b0;
			state_reg.pcsOut.wrapLoopback <= 1'b0;
			state_reg.pcsOut.fastTimer <= 1'b0;
			state_reg.pcsOut.linkMonitorLimit <= LinkMonitorCycles;
		end else begin
			state_reg <= state_next;
		end
	end

	assign hreadyout = state_reg.hreadyout;
	assign hresp = state_reg.hresp;
	assign hrdata = state_reg.hrdata;
	assign pcsOut = state_reg.pcsOut;
	assign user_word_output_bus = state_reg.userWord;

endmodule : pem_regs

// file: tb/pem_regs_asserts.sv
// Concurrent checks on bus timing, read-back fields and the PCS controls of pem_regs.
// Sees only the ports of pem_regs and is bound to every instance of it.
module pem_regs_asserts
#(parameter logic [14:0] LinkMonitorCycles = 15'h60E0) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic descramblerLock,
	input wire logic loopbackEnable,
	input wire logic fast_timer_input,
	input wire pem_pkg::pem_an_flags_t anFlags,
	input wire pem_pkg::pem_pcs_out_t pcsOut
);
	timeunit 1ns;
	timeprecision 1ps;
	import pem_pkg::*;
	logic [5:0] idx_reg;
	logic rd_reg;
	// The index of the last accepted transfer is kept so a completed read can be tied to its register.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rd_reg <= 1'b0;
		end else if (hsel && htrans[1] && hready) begin
			idx_reg <= haddr[7:2];
			rd_reg <= !hwrite;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence taken; hsel && htrans[1] && hready; endsequence
	sequence waitDone; !hreadyout ##1 hreadyout; endsequence
	sequence readDone(i); $rose(hreadyout) && rd_reg && idx_reg == i; endsequence
	AST_BUS_WAIT: assert property (taken |=> waitDone)
		else $error("transfer not answered after one wait state");
	AST_PCS_READ: assert property (readDone(IDX_PCS_CTRL) |-> hrdata[15:12] == {$past(descramblerLock), 3'h0})
		else $error("pcs control lock or unused bits wrong");
	AST_STATE_A: assert property (readDone(IDX_AN_STATE_A) |-> hrdata[15:0] == {3'h0, $past(anFlags.stateA)})
		else $error("state A read wrong");
	AST_STATE_B: assert property (readDone(IDX_AN_STATE_B) |-> hrdata[15] == ($past(anFlags[18:15]) != 4'h0))
		else $error("state B receive flag wrong");
	AST_COLLISION: assert property (!$past(reset) |-> pcsOut.collisionOff == $past(loopbackEnable))
		else $error("collision disable does not follow loopback");
	AST_FULL_LOOP: assert property (pcsOut.fullLoopback |-> pcsOut.collisionOff && pcsOut.txIdleForce)
		else $error("full loopback without its companions");
	AST_FAST: assert property (!$past(reset) && $past(fast_timer_input) |-> pcsOut.fastTimer)
		else $error("fast timer input ignored");
	AST_LIMIT: assert property (pcsOut.linkMonitorLimit == (pcsOut.fastTimer ? 15'h0190 : LinkMonitorCycles))
		else $error("link monitor limit wrong");
endmodule : pem_regs_asserts

bind pem_regs pem_regs_asserts #(.LinkMonitorCycles(LinkMonitorCycles)) assertChk (.clk_sys, .reset, .hsel, .haddr,
	.htrans, .hwrite, .hready, .hreadyout, .hrdata, .descramblerLock, .loopbackEnable, .fast_timer_input, .anFlags, .pcsOut);

// file: tb/test_phy_extended_mgmt_registers.sv
// Self-checking bench for pem_regs with expected values worked out inline in each test.
// Drives the AHB-Lite slave and all status inputs itself from one 40 MHz clock.
module test_phy_extended_mgmt_registers;
	timeunit 1ns;
	timeprecision 1ps;
	import pem_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, lock = 1'b0, loopEn = 1'b0, fastIn = 1'b0;
	logic hreadyout, hresp;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rng = 32'hD19BE524;
	logic [31:0] hrdata;
	logic [15:0] userBus, got, w;
	logic [5:0] idxList [7] = '{IDX_NEXT_PAGE, IDX_PCS_CTRL, IDX_AN_STATE_A, IDX_AN_STATE_B, IDX_USER_OUT,
		IDX_ERR_COUNT, 6'h3F};
	pem_np_link_t npLink = '0;
	pem_an_flags_t anFlags = '0;
	pem_events_t events = '0;
	pem_pcs_out_t pcsOut;
	int failCount = 0, checked = 0, n, tog;

	pem_regs #(.LinkMonitorCycles(15'h0032)) DUT (.clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .npLink, .descramblerLock(lock), .loopbackEnable(loopEn),
		.fast_timer_input(fastIn), .anFlags, .events, .pcsOut, .user_word_output_bus(userBus));

	always #12.5 clk_sys = ~clk_sys;

	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : rnd

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			failCount++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	// One single transfer; ev is pulsed so that it lands on the edge where a read clears the counter.
	task automatic xf(input logic wr, input logic [5:0] idx, input logic [15:0] d, input pem_events_t ev = '0,
			input logic [2:0] sz = 3'h2);
		@(posedge clk_sys);
		{hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'h2, 24'h0, idx, 2'h0, wr, sz};
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		{hsel, htrans, hwdata, events} <= {1'b0, 2'h0, 16'h0, d, ev};
		@(posedge clk_sys);
		events <= '0;
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		got = hrdata[15:0];
		chk(hrdata[31:16] | {15'h0, hresp}, 16'h0);
	endtask : xf

	task automatic pulse(input pem_events_t e, input int k);
		repeat (k) begin
			@(posedge clk_sys);
			events <= e;
			@(posedge clk_sys);
			events <= '0;
		end
	endtask : pulse

	task automatic reportAndStop();
		$display("checks %0d mismatches %0d", checked, failCount);
		if (failCount == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : reportAndStop

	initial begin
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		xf(1'b1, 6'h3F, 16'hFFFF);
		foreach (idxList[i]) begin
			xf(1'b0, idxList[i], 16'h0);
			chk(got, 16'h0);
		end
		$display("reset test done");
		for (int b = 0; b < 2; b++) begin
			w = 16'(rnd());
			xf(1'b1, IDX_NEXT_PAGE, w);
			for (n = 0; n < 3; n++) begin
				npLink <= {b[0], b[0], n == 0, n != 0};
				@(posedge clk_sys);
				npLink <= {b[0], b[0], 2'h0};
				tog = (n == 0) ? 1 - b : 1 - tog;
				xf(1'b0, IDX_NEXT_PAGE, 16'h0);
				chk(got, (w & 16'hB7FF) | 16'(b << 14) | 16'(tog << 11));
			end
		end
		$display("next page test done");
		for (n = 0; n < 4; n++) begin
			w = 16'(rnd());
			w[3] = n[0];
			{lock, loopEn, fastIn} <= {n[0], n[1], n[0] ^ n[1]};
			xf(1'b1, IDX_PCS_CTRL, w);
			xf(1'b0, IDX_PCS_CTRL, 16'h0);
			chk(got, {n[0], 3'h0, w[11:0]});
			chk(16'(pcsOut[19:15]), {11'h0, n[1] & w[3], n[1], n[1] & w[3], w[1], w[0] | fastIn});
			chk({1'b0, pcsOut.linkMonitorLimit}, (w[0] | fastIn) ? 16'h0190 : 16'h0032);
		end
		$display("pcs test done");
		for (n = 0; n < 4; n++) begin
			// The first round clears all four receive flags so the zero case of the top bit is seen.
			anFlags <= rnd() & ((n == 0) ? 32'hFFF8_7FFF : 32'hFFFF_FFFF);
			xf(1'b0, IDX_AN_STATE_A, 16'h0);
			chk(got, {3'h0, anFlags.stateA});
			xf(1'b0, IDX_AN_STATE_B, 16'h0);
			chk(got, {anFlags[18:15] != 4'h0, anFlags.stateB});
		end
		$display("state test done");
		w = 16'(rnd());
		xf(1'b1, IDX_USER_OUT, w);
		xf(1'b1, IDX_USER_OUT, ~w, 3'b000, 3'h1);
		xf(1'b0, IDX_USER_OUT, 16'h0);
		chk(got, w);
		chk(userBus, w);
		$display("user test done");
		n = 1 + int'(rnd() & 32'h7);
		pulse(3'b111, n);
		xf(1'b0, IDX_ERR_COUNT, 16'h0, 3'b100);
		chk(got, 16'(n));
		xf(1'b1, IDX_ERR_COUNT, 16'h0000, 3'b000, 3'h1);
		xf(1'b1, IDX_ERR_COUNT, 16'h0001);
		pulse(3'b111, n);
		pulse(3'b110, 1);
		pulse(3'b100, 1);
		xf(1'b0, IDX_ERR_COUNT, 16'h0, 3'b111);
		chk(got, {4'(n), 4'(n + 1), 8'(n + 3)});
		xf(1'b0, IDX_ERR_COUNT, 16'h0);
		chk(got, 16'h1101);
		xf(1'b1, IDX_ERR_COUNT, 16'h0000);
		pulse(3'b011, 2);
		xf(1'b0, IDX_ERR_COUNT, 16'h0);
		chk(got, 16'h0);
		$display("counter test done");
		xf(1'b1, IDX_ERR_COUNT, 16'h0001);
		reset <= 1'b1;
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		pulse(3'b011, 2);
		xf(1'b0, IDX_ERR_COUNT, 16'h0);
		chk(got, 16'h0);
		chk(userBus, 16'h0);
		$display("mid-run reset test done");
		reportAndStop();
	end

	// The tests need well under a thousand cycles; this limit is four thousand.
	initial begin
		#100us;
		failCount++;
		reportAndStop();
	end
endmodule : test_phy_extended_mgmt_registers
